// ==== art_pkg.sv ====
// Shared constants for the 12-bit autoreload PWM timer.
// Assumes an 8-bit register view carried in the low byte of a 32-bit AHB-Lite bus.
package art_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_TCS    = 6'h0D;
    localparam logic [5:0] IDX_CNT_HI = 6'h0E;
    localparam logic [5:0] IDX_CNT_LO = 6'h0F;
    localparam logic [5:0] IDX_RLD_HI = 6'h10;
    localparam logic [5:0] IDX_RLD_LO = 6'h11;
    localparam logic [5:0] IDX_PINCR  = 6'h12;
    localparam logic [5:0] IDX_PWMCSR = 6'h13;
    localparam logic [5:0] IDX_DTY_HI = 6'h17;
    localparam logic [5:0] IDX_DTY_LO = 6'h18;

    // Field positions.
    localparam int CKSEL_LSB = 3;
    localparam int OVF_BIT   = 2;
    localparam int OVERFLOW_IRQ_ENABLE_BIT = 1;
    localparam int COMPARE_IRQ_ENABLE_BIT = 0;
    localparam int PINEN_BIT = 0;
    localparam int POL_BIT   = 1;
    localparam int CMPF_BIT  = 0;

    // Counter geometry.
    localparam int          CNT_W    = 12;
    localparam logic [11:0] CNT_MAX  = 12'hFFF;
    localparam logic [11:0] CNT_ONE  = 12'h001;
    localparam logic [11:0] DUTY_OFF = 12'h000;

    // Slow mode divides the counter input by this figure.
    localparam int SLOW_DIV = 32;

    // AHB transfer type bit that marks an active transfer.
    localparam int HTRANS_ACT = 1;

    typedef enum logic [1:0] {
        CS_OFF  = 2'b00,
        CS_LITE = 2'b01,
        CS_CPU  = 2'b10,
        CS_RSVD = 2'b11
    } art_clk_sel_type;

endpackage

// ==== art_tick_if.sv ====
// Link between the timer core and its counter tick generator.
// Assumes both ends run on the system clock.
interface art_tick_if;
    art_pkg::art_clk_sel_type clk_sel;
    logic                     lite_tick;
    logic                     slow;
    logic                     halt;
    logic                     active_halt;
    logic                     ovf_ie;
    logic                     tick;

    modport gen  (input clk_sel, lite_tick, slow, halt, active_halt, ovf_ie, output tick);
    modport core (output clk_sel, lite_tick, slow, halt, active_halt, ovf_ie, input tick);
endinterface

// ==== art_tick_gen.sv ====
// Counter clock selection, slow-mode prescaler and low-power gating.
// Assumes the lite tick is a one-cycle pulse synchronous to the system clock.
module art_tick_gen #(
    parameter int DIV = art_pkg::SLOW_DIV
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Core side
    art_tick_if.gen  tif
);
    localparam int PW = $clog2(DIV);
    localparam logic [PW-1:0] PRE_LAST = PW'(DIV - 1);
    localparam logic [PW-1:0] PRE_ONE  = PW'(1);

    typedef struct packed {
        logic [PW-1:0] pre;
        logic          tick;
    } art_tick_state_type;

    art_tick_state_type q;
    art_tick_state_type n;
    logic               src;
    logic               run;

    always_comb
    begin
        n = q;
        n.tick = 1'b0;
        case (tif.clk_sel)
            art_pkg::CS_LITE: src = tif.lite_tick;
            art_pkg::CS_CPU:  src = 1'b1;
            default:          src = 1'b0;
        endcase
        // Active-halt keeps only the lite tick running, and only for overflow wake-up.
        run = !tif.halt && (!tif.active_halt ||
              (tif.clk_sel == art_pkg::CS_LITE && tif.ovf_ie));
        if (run && src)
        begin
            if (!tif.slow)
                n.tick = 1'b1;
            else if (q.pre == PRE_LAST)
            begin
                n.pre = '0;
                n.tick = 1'b1;
            end
            else
                n.pre = q.pre + PRE_ONE;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= n;
    end

    assign tif.tick = q.tick;

    property p_halt_stops;
        @(posedge clk_sys) disable iff (!rst_n)
        tif.halt |=> !tif.tick;
    endproperty
    a_halt_stops: assert property (p_halt_stops) else $error("tick during halt");

    property p_off_stops;
        @(posedge clk_sys) disable iff (!rst_n)
        (tif.clk_sel == art_pkg::CS_OFF) |=> !tif.tick;
    endproperty
    a_off_stops: assert property (p_off_stops) else $error("tick with clock off");

endmodule // art_tick_gen

// ==== art_timer_top.sv ====
// 12-bit autoreload timer with one PWM output and output compare.
// Assumes an AHB-Lite master with single word transfers; register data in bits 7:0.

module art_timer_top #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              CLK_SYS,
    input  wire logic              RST_N,
    // AHB-Lite slave
    input  wire logic              HSEL,
    input  wire logic [ADDR_W-1:0] HADDR,
    input  wire logic [1:0]        HTRANS,
    input  wire logic              HWRITE,
    input  wire logic [2:0]        HSIZE,
    input  wire logic [31:0]       HWDATA,
    input  wire logic              HREADY,
    output logic      [31:0]       HRDATA,
    output logic                   HREADYOUT,
    output logic                   HRESP,
    // Counter clock source and power modes
    input  wire logic              LITE_TICK,
    input  wire logic              SLOW_MODE,
    input  wire logic              HALT_MODE,
    input  wire logic              ACTIVE_HALT_MODE,
    // PWM pin
    output logic                   PWM_PIN_O,
    output logic                   PWM_PIN_OE_N,
    // Interrupt requests
    output logic                   OVF_IRQ,
    output logic                   CMP_IRQ
);
    localparam int W = art_pkg::CNT_W;

    typedef struct packed {
        logic [1:0]   clk_sel;
        logic         ovf_ie;
        logic         cmp_ie;
        logic         ovf;
        logic         ovf_clr;
        logic [W-1:0] cnt;
        logic [W-1:0] reload;
        logic [W-1:0] duty;
        logic [W-1:0] shadow;
        logic         locked;
        logic         pwm_en;
        logic         pol;
        logic         cmp;
        logic         pwm;
        logic         wr_pend;
        logic [5:0]   wr_idx;
        logic         rd_pend;
        logic [5:0]   rd_idx;
        logic [31:0]  rdata;
        logic         ready;
        logic         resp;
        logic         pin_o;
        logic         pin_oe_n;
        logic         ovf_irq;
        logic         cmp_irq;
    } art_state_type;

    art_state_type q;
    art_state_type n;
    logic          acc;
    logic          tick;
    logic [W-1:0]  cmp_val;
    logic          cmp_hit;
    logic          wrap;
    logic [7:0]    wd;

    art_tick_if tif ();

    function automatic logic [5:0] addr_idx(input logic [ADDR_W-1:0] a);
        addr_idx = a[7:2];
    endfunction

    function automatic logic [7:0] read_reg(input art_state_type s, input logic [5:0] idx);
        read_reg = 8'h00;
        if (idx == art_pkg::IDX_TCS)
        begin
            read_reg[art_pkg::CKSEL_LSB +: 2] = s.clk_sel;
            read_reg[art_pkg::OVF_BIT]        = s.ovf;
            read_reg[art_pkg::OVERFLOW_IRQ_ENABLE_BIT]      = s.ovf_ie;
            read_reg[art_pkg::COMPARE_IRQ_ENABLE_BIT]      = s.cmp_ie;
        end
        else if (idx == art_pkg::IDX_CNT_HI)
            read_reg = {4'h0, s.cnt[11:8]};
        else if (idx == art_pkg::IDX_CNT_LO)
            read_reg = s.cnt[7:0];
        else if (idx == art_pkg::IDX_RLD_HI)
            read_reg = {4'h0, s.reload[11:8]};
        else if (idx == art_pkg::IDX_RLD_LO)
            read_reg = s.reload[7:0];
        else if (idx == art_pkg::IDX_PINCR)
            read_reg[art_pkg::PINEN_BIT] = s.pwm_en;
        else if (idx == art_pkg::IDX_PWMCSR)
        begin
            read_reg[art_pkg::POL_BIT]  = s.pol;
            read_reg[art_pkg::CMPF_BIT] = s.cmp;
        end
        else if (idx == art_pkg::IDX_DTY_HI)
            read_reg = {4'h0, s.duty[11:8]};
        else if (idx == art_pkg::IDX_DTY_LO)
            read_reg = s.duty[7:0];
    endfunction

    assign tif.clk_sel     = art_pkg::art_clk_sel_type'(q.clk_sel);
    assign tif.lite_tick   = LITE_TICK;
    assign tif.slow        = SLOW_MODE;
    assign tif.halt        = HALT_MODE;
    assign tif.active_halt = ACTIVE_HALT_MODE;
    assign tif.ovf_ie      = q.ovf_ie;
    assign tick            = tif.tick;

    art_tick_gen #(
        .DIV (art_pkg::SLOW_DIV)
    ) art_tick_gen_i (
        .clk_sys (CLK_SYS),
        .rst_n   (RST_N),
        .tif     (tif.gen)
    );

    assign acc  = HSEL && HTRANS[art_pkg::HTRANS_ACT] && HREADY;
    assign wd   = HWDATA[7:0];
    assign wrap = tick && (q.cnt == art_pkg::CNT_MAX);

    always_comb
    begin
        n = q;
        n.ready = 1'b1;
        n.wr_pend = 1'b0;
        n.rd_pend = 1'b0;

        // Write data phase; unmapped indices are ignored.
        if (q.wr_pend)
        begin
            if (q.wr_idx == art_pkg::IDX_TCS)
            begin
                n.clk_sel = wd[art_pkg::CKSEL_LSB +: 2];
                n.ovf_ie  = wd[art_pkg::OVERFLOW_IRQ_ENABLE_BIT];
                n.cmp_ie  = wd[art_pkg::COMPARE_IRQ_ENABLE_BIT];
            end
            else if (q.wr_idx == art_pkg::IDX_RLD_HI)
                n.reload[11:8] = wd[3:0];
            else if (q.wr_idx == art_pkg::IDX_RLD_LO)
                n.reload[7:0] = wd;
            else if (q.wr_idx == art_pkg::IDX_PINCR)
                n.pwm_en = wd[art_pkg::PINEN_BIT];
            else if (q.wr_idx == art_pkg::IDX_PWMCSR)
                n.pol = wd[art_pkg::POL_BIT];
            else if (q.wr_idx == art_pkg::IDX_DTY_HI)
            begin
                n.duty[11:8] = wd[3:0];
                n.locked = 1'b1;
            end
            else if (q.wr_idx == art_pkg::IDX_DTY_LO)
            begin
                n.duty[7:0] = wd;
                n.locked = 1'b0;
            end
        end

        // Read data phase, one wait state; reads carry the flag clears.
        if (q.rd_pend)
        begin
            n.rdata = {24'h000000, read_reg(q, q.rd_idx)};
            if (q.rd_idx == art_pkg::IDX_TCS && q.ovf)
                n.ovf_clr = 1'b1;
            if (q.rd_idx == art_pkg::IDX_PWMCSR)
                n.cmp = 1'b0;
        end

        if (acc)
        begin
            if (HWRITE)
            begin
                n.wr_pend = 1'b1;
                n.wr_idx  = addr_idx(HADDR);
            end
            else
            begin
                n.rd_pend = 1'b1;
                n.rd_idx  = addr_idx(HADDR);
                n.ready   = 1'b0;
            end
        end

        // A pending clear takes effect one counter tick later, or at once with the clock selection off.
        if (q.ovf_clr && (tick || q.clk_sel == art_pkg::CS_OFF))
        begin
            n.ovf = 1'b0;
            n.ovf_clr = 1'b0;
        end

        if (tick)
        begin
            if (wrap)
            begin
                n.cnt = q.reload;
                n.ovf = 1'b1;
                n.ovf_clr = 1'b0;
                n.shadow = n.duty;
                n.pwm = 1'b1;
            end
            else
                n.cnt = q.cnt + art_pkg::CNT_ONE;
        end

        // Pin enabled compares the shadow, otherwise the live duty value.
        cmp_val = n.pwm_en ? n.shadow : n.duty;
        cmp_hit = tick && !n.locked && (cmp_val != art_pkg::DUTY_OFF) &&
                  (n.cnt == cmp_val);
        if (cmp_hit)
        begin
            n.cmp = 1'b1;
            n.pwm = 1'b0;
        end

        n.pin_o    = n.pwm ^ n.pol;
        n.pin_oe_n = !n.pwm_en;
        n.ovf_irq  = n.ovf && n.ovf_ie;
        n.cmp_irq  = n.cmp && n.cmp_ie;
        n.resp     = 1'b0;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            q <= '0;
            q.ready <= 1'b1;
            q.pin_oe_n <= 1'b1;
        end
        else
            q <= n;
    end

    assign HRDATA       = q.rdata;
    assign HREADYOUT    = q.ready;
    assign HRESP        = q.resp;
    assign PWM_PIN_O    = q.pin_o;
    assign PWM_PIN_OE_N = q.pin_oe_n;
    assign OVF_IRQ      = q.ovf_irq;
    assign CMP_IRQ      = q.cmp_irq;

    property p_pin_enable;
        @(posedge CLK_SYS) disable iff (!RST_N)
        $rose(q.pwm_en) |-> !PWM_PIN_OE_N && $past(PWM_PIN_OE_N);
    endproperty
    a_pin_enable: assert property (p_pin_enable) else $error("pin enable mismatch");

    property p_wrap;
        @(posedge CLK_SYS) disable iff (!RST_N)
        wrap |=> q.cnt == $past(q.reload) && q.ovf && q.shadow == $past(n.duty);
    endproperty
    a_wrap: assert property (p_wrap) else $error("overflow reload wrong");

    property p_count_up;
        @(posedge CLK_SYS) disable iff (!RST_N)
        tick && !wrap |=> q.cnt == $past(q.cnt) + art_pkg::CNT_ONE;
    endproperty
    a_count_up: assert property (p_count_up) else $error("counter did not step");

    property p_match_low;
        @(posedge CLK_SYS) disable iff (!RST_N)
        cmp_hit |=> q.cmp && !q.pwm && (PWM_PIN_O == q.pol);
    endproperty
    a_match_low: assert property (p_match_low) else $error("match did not drive low");

    property p_locked;
        @(posedge CLK_SYS) disable iff (!RST_N)
        q.locked && !q.wr_pend |=> !$rose(q.cmp);
    endproperty
    a_locked: assert property (p_locked) else $error("compare while locked");

    property p_zero_duty;
        @(posedge CLK_SYS) disable iff (!RST_N)
        !q.pwm_en && !q.wr_pend && q.duty == art_pkg::DUTY_OFF |=> !$rose(q.cmp);
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("compare on zero duty");

    property p_ovf_linger;
        @(posedge CLK_SYS) disable iff (!RST_N)
        q.rd_pend && q.rd_idx == art_pkg::IDX_TCS && q.ovf && !q.ovf_clr |=> q.ovf ##1 1'b1;
    endproperty
    a_ovf_linger: assert property (p_ovf_linger) else $error("overflow flag dropped early");

    property p_set_wins;
        @(posedge CLK_SYS) disable iff (!RST_N)
        wrap && q.rd_pend && q.rd_idx == art_pkg::IDX_TCS |=> q.ovf && !q.ovf_clr;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("overflow lost to clear");

    property p_ovf_irq;
        @(posedge CLK_SYS) disable iff (!RST_N)
        $rose(q.ovf) && q.ovf_ie |-> OVF_IRQ;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request missing");

    property p_read_wait;
        @(posedge CLK_SYS) disable iff (!RST_N)
        acc && !HWRITE |=> !HREADYOUT ##1 HREADYOUT;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read timing wrong");

endmodule // art_timer_top

// ==== tb_autoreload_pwm_timer12.sv ====
// Self-checking bench for the 12-bit autoreload PWM timer, driven over AHB-Lite.
// Assumes the package, tick interface, tick generator and timer top are compiled first.
module tb_autoreload_pwm_timer12;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys    = 1'h0;
    logic        rst_n      = 1'h0;
    logic        hsel       = 1'h0;
    logic [7:0]  haddr      = 8'h00;
    logic [1:0]  htrans     = 2'h0;
    logic        hwrite     = 1'h0;
    logic [31:0] hwdata     = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        lite_tick  = 1'h0;
    logic        slow_mode  = 1'h0;
    logic        halt_mode  = 1'h0;
    logic        ahalt_mode = 1'h0;
    logic        pwm_o;
    logic        pwm_oe_n;
    logic        ovf_irq;
    logic        cmp_irq;
    int          n_fail       = 0;
    int          total_checks = 0;

    always #5 clk_sys = ~clk_sys;

    art_timer_top art_timer_top_i (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .LITE_TICK(lite_tick), .SLOW_MODE(slow_mode),
        .HALT_MODE(halt_mode), .ACTIVE_HALT_MODE(ahalt_mode), .PWM_PIN_O(pwm_o),
        .PWM_PIN_OE_N(pwm_oe_n), .OVF_IRQ(ovf_irq), .CMP_IRQ(cmp_irq)
    );

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Returns at the edge where ready is sampled high.
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (hreadyout !== 1'h1 && n < 50);
        if (n >= 50)
        begin
            n_fail++;
            $display("[ERR] %0t bus wait ran out", $time);
            conclude();
        end
    endtask

    task automatic bus(input logic [5:0] idx, input logic w, input logic [7:0] wd, output logic [7:0] rd);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= {idx, 2'h0};
        hwrite <= w;
        wait_ready();
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata[7:0];
    endtask

    // The extra edge lets the written register reach the outputs before anything is sampled.
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(idx, 1'h1, d, x);
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [5:0] idx, output logic [7:0] x);
        bus(idx, 1'h0, 8'h00, x);
        check({11'h0, hresp}, 12'h000, "hresp");
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] x;
        rd(idx, x);
        check({4'h0, x}, {4'h0, exp}, what);
    endtask

    task automatic cnt_chk(input logic [11:0] exp, input string what);
        rd_chk(art_pkg::IDX_CNT_LO, exp[7:0], what);
        rd_chk(art_pkg::IDX_CNT_HI, {4'h0, exp[11:8]}, what);
    endtask

    task automatic tick(input int n);
        repeat (n)
        begin
            lite_tick <= 1'h1;
            @(posedge clk_sys);
            lite_tick <= 1'h0;
            @(posedge clk_sys);
        end
        repeat (3) @(posedge clk_sys);
    endtask

    // Counts high pin cycles over two 16-cycle periods once the shadow has settled.
    task automatic pwm_chk(input logic [11:0] exp, input string what);
        logic [11:0] hi;
        hi = 12'h000;
        repeat (40) @(posedge clk_sys);
        repeat (32)
        begin
            @(posedge clk_sys);
            hi = hi + {11'h0, pwm_o};
        end
        check(hi, exp, what);
    endtask

    task automatic t_reset();
        logic [5:0] regs [11];
        regs = '{art_pkg::IDX_TCS, art_pkg::IDX_CNT_HI, art_pkg::IDX_CNT_LO, art_pkg::IDX_RLD_HI,
                 art_pkg::IDX_RLD_LO, art_pkg::IDX_PINCR, art_pkg::IDX_PWMCSR, art_pkg::IDX_DTY_HI,
                 art_pkg::IDX_DTY_LO, 6'h00, 6'h15};
        foreach (regs[i])
        begin
            rd_chk(regs[i], 8'h00, "reset value");
        end
        check({11'h0, pwm_oe_n}, 12'h001, "pin enable");
        check({10'h0, ovf_irq, cmp_irq}, 12'h000, "irq");
    endtask

    task automatic t_clock();
        tick(3);
        cnt_chk(12'h000, "off");
        wr(art_pkg::IDX_TCS, 8'h08);
        tick(5);
        cnt_chk(12'h005, "lite");
        halt_mode <= 1'h1;
        tick(2);
        cnt_chk(12'h005, "halt");
        halt_mode  <= 1'h0;
        ahalt_mode <= 1'h1;
        tick(2);
        cnt_chk(12'h005, "ahalt");
        wr(art_pkg::IDX_TCS, 8'h0A);
        tick(2);
        cnt_chk(12'h007, "ahalt irq");
        ahalt_mode <= 1'h0;
        wr(art_pkg::IDX_TCS, 8'h18);
        tick(2);
        cnt_chk(12'h007, "reserved");
    endtask

    task automatic t_regs();
        wr(art_pkg::IDX_RLD_HI, 8'h0F);
        wr(art_pkg::IDX_RLD_LO, 8'hF0);
        wr(art_pkg::IDX_CNT_LO, 8'h55);
        wr(6'h15, 8'hAA);
        wr(art_pkg::IDX_TCS, 8'h0C);
        rd_chk(art_pkg::IDX_RLD_HI, 8'h0F, "reload hi");
        rd_chk(art_pkg::IDX_RLD_LO, 8'hF0, "reload lo");
        rd_chk(art_pkg::IDX_CNT_LO, 8'h07, "counter ro");
        rd_chk(6'h15, 8'h00, "unmapped");
        rd_chk(art_pkg::IDX_TCS, 8'h08, "flag ro");
    endtask

    task automatic t_compare();
        wr(art_pkg::IDX_TCS, 8'h09);
        wr(art_pkg::IDX_DTY_HI, 8'h00);
        wr(art_pkg::IDX_DTY_LO, 8'h0A);
        tick(2);
        check({11'h0, cmp_irq}, 12'h000, "early cmp");
        tick(1);
        check({11'h0, cmp_irq}, 12'h001, "cmp irq");
        check({11'h0, pwm_oe_n}, 12'h001, "output_compare_mode pin");
        rd_chk(art_pkg::IDX_PWMCSR, 8'h01, "cmp flag");
        rd_chk(art_pkg::IDX_PWMCSR, 8'h00, "cmp clear");
        check({11'h0, cmp_irq}, 12'h000, "cmp irq off");
        wr(art_pkg::IDX_TCS, 8'h0B);
        tick(4085);
        cnt_chk(12'hFFF, "top");
        check({11'h0, ovf_irq}, 12'h000, "no ovf");
        tick(1);
        cnt_chk(12'hFF0, "reload");
        check({11'h0, ovf_irq}, 12'h001, "ovf irq");
        rd_chk(art_pkg::IDX_TCS, 8'h0F, "ovf set");
        rd_chk(art_pkg::IDX_TCS, 8'h0F, "ovf linger");
        tick(1);
        rd_chk(art_pkg::IDX_TCS, 8'h0B, "ovf clear");
        check({11'h0, ovf_irq}, 12'h000, "ovf irq off");
        wr(art_pkg::IDX_TCS, 8'h09);
        tick(16);
        check({11'h0, ovf_irq}, 12'h000, "ovf masked");
        cnt_chk(12'hFF1, "period");
        rd_chk(art_pkg::IDX_TCS, 8'h0D, "ovf again");
    endtask

    task automatic t_pwm();
        logic [7:0] a;
        logic [7:0] b;
        logic [3:0] d;
        wr(art_pkg::IDX_TCS, 8'h10);
        wr(art_pkg::IDX_DTY_HI, 8'h0F);
        wr(art_pkg::IDX_DTY_LO, 8'hF4);
        wr(art_pkg::IDX_PINCR, 8'h01);
        check({11'h0, pwm_oe_n}, 12'h000, "pin on");
        pwm_chk(12'h008, "duty");
        wr(art_pkg::IDX_PWMCSR, 8'h02);
        pwm_chk(12'h018, "inverted");
        wr(art_pkg::IDX_DTY_HI, 8'h0F);
        wr(art_pkg::IDX_DTY_LO, 8'hF0);
        pwm_chk(12'h020, "full");
        wr(art_pkg::IDX_PWMCSR, 8'h00);
        pwm_chk(12'h000, "zero");
        wr(art_pkg::IDX_DTY_HI, 8'h0F);
        wr(art_pkg::IDX_DTY_LO, 8'hF4);
        wr(art_pkg::IDX_DTY_HI, 8'h0F);
        pwm_chk(12'h020, "locked");
        wr(art_pkg::IDX_DTY_LO, 8'hF4);
        pwm_chk(12'h008, "unlocked");
        // Reads spaced three cycles apart sweep every phase of the 16-cycle period, so one meets a wrap.
        repeat (16)
        begin
            rd(art_pkg::IDX_TCS, a);
            check({4'h0, a & 8'hFB}, 12'h010, "csr cpu");
        end
        rd(art_pkg::IDX_CNT_LO, a);
        rd(art_pkg::IDX_CNT_LO, b);
        d = b[3:0] - a[3:0];
        check({8'h0, d}, 12'h003, "cpu rate");
        slow_mode <= 1'h1;
        repeat (64) @(posedge clk_sys);
        rd(art_pkg::IDX_CNT_LO, a);
        repeat (157) @(posedge clk_sys);
        rd(art_pkg::IDX_CNT_LO, b);
        d = b[3:0] - a[3:0];
        check({8'h0, d}, 12'h005, "slow rate");
        wr(art_pkg::IDX_PINCR, 8'h00);
        check({11'h0, pwm_oe_n}, 12'h001, "pin off");
    endtask

    // Zero duty with a zero reload puts the counter on zero at every wrap; no compare may follow.
    task automatic t_zero();
        slow_mode <= 1'h0;
        wr(art_pkg::IDX_DTY_HI, 8'h00);
        wr(art_pkg::IDX_DTY_LO, 8'h00);
        wr(art_pkg::IDX_RLD_HI, 8'h00);
        wr(art_pkg::IDX_RLD_LO, 8'h00);
        rd_chk(art_pkg::IDX_PWMCSR, 8'h01, "cmp flag pwm");
        repeat (4200) @(posedge clk_sys);
        rd_chk(art_pkg::IDX_PWMCSR, 8'h00, "zero duty");
    endtask

    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        t_reset();
        t_clock();
        t_regs();
        t_compare();
        t_pwm();
        t_zero();
        conclude();
    end

    initial
    begin
        repeat (100000) @(posedge clk_sys);
        n_fail++;
        $display("[ERR] %0t run did not finish", $time);
        conclude();
    end
endmodule // tb_autoreload_pwm_timer12
